// ---- sim/sros_xtal_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module sros_xtal_model
#(
  parameter int START_DLY = 40
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // crystal
  input wire logic en_i,
  output logic tick_o,
  output logic started_o
);
  int cnt_q;
  // ---------------------------------------------------------------
  // ticks begin before start is flagged, to expose early counting
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !en_i)
    begin
      cnt_q <= 0;
      tick_o <= 1'b0;
      started_o <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 1;
      tick_o <= (cnt_q >= START_DLY / 2) && cnt_q[0];
      started_o <= (cnt_q >= START_DLY);
    end
  end
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench
  import sros_pkg::*;
;
  typedef struct packed {logic [3:0] a; logic [7:0] w; logic [7:0] e;} sros_row_t;
  localparam sros_row_t ROWS [7] = '{
    '{ADDR_WAIT_SEL, 8'h02, 8'h02},
    '{ADDR_WAIT_SEL, 8'h07, {5'h00, WAIT_SEL_MAX}},
    '{4'hf, 8'h5a, 8'h00},
    '{ADDR_FLAGS, 8'h1f, 8'h00},
    '{ADDR_CTRL, 8'h03, 8'h03},
    '{ADDR_CTRL, 8'h00, 8'h00},
    '{ADDR_WAIT_SEL, 8'h00, 8'h00}};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic halt_opt = 1'b0;
  logic release_s = 1'b0;
  logic tick, started, cpu_run, osc_en, ring_en;
  logic [7:0] rdata;
  logic [PRE_W-1:0] pre;
  int mismatches = 0;
  int total_checks = 0;
  logic [7:0] d;
  logic [PRE_W-1:0] p0;
  // ---------------------------------------------------------------
  // clock, design and crystal
  // ---------------------------------------------------------------
  always #5 mclk = ~mclk;
  sros_top sros_top_i (.MCLK_I(mclk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .HALT_OPTION_I(halt_opt),
    .MAIN_CRYSTAL_TICK_I(tick), .OSC_STARTED_I(started), .RELEASE_I(release_s),
    .CPU_RUN_O(cpu_run), .MAIN_OSC_EN_O(osc_en), .RING_OSC_EN_O(ring_en),
    .PRESCALER_O(pre));
  sros_xtal_model sros_xtal_model_i (.clk_i(mclk), .rst_i(rst), .en_i(osc_en),
    .tick_o(tick), .started_o(started));
  // ---------------------------------------------------------------
  // bus tasks and compare
  // ---------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge mclk);
    addr <= a;
    wdata <= w;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] r);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1;
    r = rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // stop, release, then time the wait from crystal start to cpu run
  task automatic stop_run(input int sel, input logic src);
    int n;
    int exp;
    logic [7:0] r;
    exp = (sel == 0) ? 0 : 2 * (2 ** (10 + sel));
    wr(ADDR_WAIT_SEL, 8'(sel));
    wr(ADDR_CTRL, {5'h00, 1'b1, src, 1'b0});
    repeat (2) @(posedge mclk);
    #1;
    chk({7'h00, cpu_run}, 8'h00);
    chk({7'h00, osc_en}, {7'h00, src});
    rd(ADDR_FLAGS, r);
    chk(r, 8'h00);
    rd(ADDR_STATUS, r);
    chk(r, {4'h0, 1'b1, src, ST_STOP});
    @(posedge mclk);
    release_s <= 1'b1;
    @(posedge mclk);
    release_s <= 1'b0;
    n = 0;
    while (started !== 1'b1 && n < 2000)
    begin
      @(posedge mclk);
      n++;
    end
    chk({7'h00, started}, 8'h01);
    n = 0;
    while (cpu_run !== 1'b1 && n < 20000)
    begin
      @(posedge mclk);
      n++;
    end
    chk({7'h00, n >= exp && n <= exp + 6}, 8'h01);
    rd(ADDR_FLAGS, r);
    chk(r, 8'((1 << sel) - 1));
    $display("test stop with select %0d source %0d done", sel, src);
  endtask
  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial
  begin
    #500us;
    mismatches++;
    close_out();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(ADDR_WAIT_SEL, d);
    chk(d, {5'h00, WAIT_SEL_RST});
    chk({7'h00, cpu_run}, 8'h01);
    chk({7'h00, ring_en}, 8'h01);
    $display("test reset done");
    foreach (ROWS[i])
    begin
      wr(ROWS[i].a, ROWS[i].w);
      rd(ROWS[i].a, d);
      chk(d, ROWS[i].e);
      @(posedge mclk);
      #1;
      chk(rdata, 8'h00);
    end
    $display("test register rows done");
    for (int s = 0; s < 3; s++)
      stop_run(s, 1'b0);
    stop_run(1, 1'b1);
    wr(ADDR_CTRL, 8'h01);
    repeat (3) @(posedge mclk);
    chk({7'h00, ring_en}, 8'h01);
    halt_opt <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({7'h00, ring_en}, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    repeat (3) @(posedge mclk);
    chk({7'h00, ring_en}, 8'h01);
    $display("test halt option done");
    wr(ADDR_CTRL, 8'h04);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(ADDR_WAIT_SEL, d);
    chk(d, {5'h00, WAIT_SEL_RST});
    rd(ADDR_FLAGS, d);
    chk(d, 8'h00);
    chk({7'h00, cpu_run}, 8'h01);
    chk({7'h00, osc_en}, 8'h01);
    $display("test reset in stop done");
    wr(ADDR_CTRL, 8'h02);
    repeat (3) @(posedge mclk);
    p0 = pre;
    repeat (4 * (CLK_HZ / RING_TYP_HZ)) @(posedge mclk);
    d = 8'(pre - p0);
    chk({7'h00, d >= 8'h03 && d <= 8'h05}, 8'h01);
    $display("test ring prescaler done");
    p0 = pre;
    repeat (4 * RING_DIV_SLOW) @(posedge mclk);
    d = 8'(pre - p0);
    chk({7'h00, d >= 8'h04}, 8'h01);
    $display("test ring worst case done");
    close_out();
  end
endmodule
`default_nettype wire

// ---- src/sros_pkg.sv ----
package sros_pkg;
  // ---------------------------------------------------------------
  // register map (plain port, word index)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_WAIT_SEL = 4'h0;  // stab_wait_select
  localparam logic [3:0] ADDR_FLAGS = 4'h1;     // stab_progress_flags
  localparam logic [3:0] ADDR_CTRL = 4'h2;      // ring_osc_halt, clock source, stop request
  localparam logic [3:0] ADDR_STATUS = 4'h3;    // state and oscillator status
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int FLAG_W = 5;
  localparam logic [2:0] WAIT_SEL_RST = 3'h5;
  localparam logic [2:0] WAIT_SEL_MAX = 3'h5;
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;
  // counts of crystal cycles per step, step k ends at 2^(STEP_BASE+k)
  localparam int STEP_BASE = 11;
  localparam int CNT_W = STEP_BASE + FLAG_W;
  // ---------------------------------------------------------------
  // ring oscillator timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int RING_TYP_HZ = 240_000;
  localparam int RING_MIN_HZ = 120_000;
  localparam int RING_DIV = CLK_HZ / RING_TYP_HZ;       // rounds down
  localparam int RING_DIV_SLOW = CLK_HZ / RING_MIN_HZ;  // worst case
  localparam int PRE_W = 8;
  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOP = 2'b01,
    ST_START = 2'b11,
    ST_WAIT = 2'b10
  } sros_state_t;
  typedef struct packed {
    logic halt;
    logic src_ring;
  } sros_ctrl_t;
endpackage

// ---- src/sros_ring_div.sv ----
`timescale 1ns/100ps
`default_nettype none
module sros_ring_div
  import sros_pkg::*;
#(
  parameter int DIV = RING_DIV
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic tick_o
);
  localparam int CW = $clog2(DIV + 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic tick_d;

  initial
  begin
    if (DIV < 2)
      $error("ring divider must be at least 2");
  end

  // count clock cycles per ring oscillator period
  always_comb
  begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (run_i)
    begin
      if (cnt_q == CW'(DIV - 1))
      begin
        cnt_d = '0;
        tick_d = 1'b1;
      end
      else
        cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_o <= tick_d;
    end
  end
endmodule
`default_nettype wire

// ---- src/sros_top.sv ----
// Behaviour
// (RULE1) with the ring clock feeding the cpu, software picks a wait no shorter than it polls.
// (RULE2) the stabilization counter stops at the selected wait so no later flag ever sets.
// (RULE3) counting starts only once the crystal has started oscillating, whatever released stop.
// (RULE4) with the ring clock selected the prescaler divides the ring oscillator output.
// (RULE5) the ring halt control acts only when the halt option strap allows it.
// (RULE6) worst-case ring durations are worked out at 120 kHz.
// (RULE7) flags set one by one from the shortest step and then stay set.
// (RULE8) with the crystal feeding the cpu, software sets the wait select before stop.
// (RULE9) software confirms the elapsed wait from the flags before changing the select.
// (RULE10) stop entry clears the flags; release counts from zero and resumes at the wait.
`timescale 1ns/100ps
`default_nettype none
module sros_top
  import sros_pkg::*;
#(
  parameter int STEPS = FLAG_W
)
(
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_I,
  // register port
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // oscillator and standby
  input wire logic HALT_OPTION_I,
  input wire logic MAIN_CRYSTAL_TICK_I,
  input wire logic OSC_STARTED_I,
  input wire logic RELEASE_I,
  output logic CPU_RUN_O,
  output logic MAIN_OSC_EN_O,
  output logic RING_OSC_EN_O,
  output logic [PRE_W-1:0] PRESCALER_O
);
  initial
  begin
    if (STEPS != FLAG_W)
      $error("step count must match the flag field width");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sros_state_t st_q, st_d;
  logic [2:0] sel_q, sel_d;
  logic [FLAG_W-1:0] flags_q, flags_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  sros_ctrl_t ctrl_q, ctrl_d;
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [7:0] rdata_d;
  logic run_d, main_en_d, ring_en_d;
  logic ring_tick;

  // step k elapsed once the count reaches 2^(STEP_BASE+k)
  function automatic logic step_done(input logic [CNT_W-1:0] c, input int k);
    step_done = (c >= (CNT_W'(1) << (STEP_BASE + k)));
  endfunction

  // ring enable: halt honoured only with option strap
  assign ring_en_d = !(ctrl_q.halt && HALT_OPTION_I); // RULE5

  sros_ring_div #(.DIV(RING_DIV)) u_div (
    .clk_i(MCLK_I),
    .rst_i(RST_I),
    .run_i(ring_en_d),
    .tick_o(ring_tick)
  );

  // ---------------------------------------------------------------
  // standby sequence and registers
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    sel_d = sel_q;
    flags_d = flags_q;
    cnt_d = cnt_q;
    ctrl_d = ctrl_q;
    if (WR_I && ADDR_I == ADDR_WAIT_SEL)
      sel_d = (WDATA_I[2:0] > WAIT_SEL_MAX) ? WAIT_SEL_MAX : WDATA_I[2:0];
    if (WR_I && ADDR_I == ADDR_CTRL)
    begin
      ctrl_d.halt = WDATA_I[CTRL_HALT_BIT];
      ctrl_d.src_ring = WDATA_I[CTRL_SRC_BIT];
    end
    unique case (st_q)
      ST_RUN:
      begin
        if (WR_I && ADDR_I == ADDR_CTRL && WDATA_I[CTRL_STOP_BIT])
        begin
          st_d = ST_STOP;
          flags_d = '0; // RULE10
        end
      end
      ST_STOP:
      begin
        if (RELEASE_I)
          st_d = ST_START;
      end
      ST_START:
      begin
        cnt_d = '0;
        if (OSC_STARTED_I)
          st_d = ST_WAIT; // RULE3
      end
      ST_WAIT:
      begin
        if (MAIN_CRYSTAL_TICK_I)
          cnt_d = cnt_q + 1'b1; // RULE10
        for (int k = 0; k < FLAG_W; k++)
        begin
          if (k < int'(sel_q) && step_done(cnt_q, k))
            flags_d[k] = 1'b1; // RULE7 RULE2
        end
        if (sel_q == '0 || step_done(cnt_q, int'(sel_q) - 1))
          st_d = ST_RUN; // RULE2 RULE10
      end
    endcase
  end

  // cpu and crystal enables, read data, prescaler
  always_comb
  begin
    run_d = (st_d == ST_RUN);
    main_en_d = (st_d != ST_STOP) || ctrl_d.src_ring;
    rdata_d = 8'h00;
    if (RD_I)
    begin
      unique case (ADDR_I)
        ADDR_WAIT_SEL: rdata_d = {5'h00, sel_q};
        ADDR_FLAGS: rdata_d = {3'h0, flags_q};
        ADDR_CTRL: rdata_d = {6'h00, ctrl_q.src_ring, ctrl_q.halt};
        ADDR_STATUS: rdata_d = {4'h0, ring_en_d, OSC_STARTED_I, st_q};
        default: rdata_d = 8'h00;
      endcase
    end
    pre_d = pre_q;
    if (ctrl_q.src_ring ? ring_tick : MAIN_CRYSTAL_TICK_I)
      pre_d = pre_q + 1'b1; // RULE4
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      st_q <= ST_RUN;
      sel_q <= WAIT_SEL_RST;
      flags_q <= '0;
      cnt_q <= '0;
      ctrl_q <= '0;
      pre_q <= '0;
      RDATA_O <= 8'h00;
      CPU_RUN_O <= 1'b1;
      MAIN_OSC_EN_O <= 1'b1;
      RING_OSC_EN_O <= 1'b1;
      PRESCALER_O <= '0;
    end
    else
    begin
      st_q <= st_d;
      sel_q <= sel_d;
      flags_q <= flags_d;
      cnt_q <= cnt_d;
      ctrl_q <= ctrl_d;
      pre_q <= pre_d;
      RDATA_O <= rdata_d;
      CPU_RUN_O <= run_d;
      MAIN_OSC_EN_O <= main_en_d;
      RING_OSC_EN_O <= ring_en_d;
      PRESCALER_O <= pre_d;
    end
  end

  // ---------------------------------------------------------------
  // ring period watch for the checks below
  // ---------------------------------------------------------------
  localparam int GAP_W = $clog2(RING_DIV_SLOW + 1);
  localparam logic [GAP_W-1:0] GAP_MAX = GAP_W'(RING_DIV_SLOW);
  logic [GAP_W-1:0] gap_q, gap_d;

  // cycles since the last ring tick, held at the worst-case period
  always_comb
  begin
    gap_d = gap_q;
    if (!ring_en_d || ring_tick)
      gap_d = '0;
    else if (gap_q != GAP_MAX)
      gap_d = gap_q + 1'b1;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
      gap_q <= '0;
    else
      gap_q <= gap_d;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_stop_entry;
    st_q == ST_RUN && st_d == ST_STOP;
  endsequence

  sequence s_wait_done;
    st_q == ST_WAIT && st_d == ST_RUN;
  endsequence

  property p_no_flag_beyond;
    @(posedge MCLK_I) disable iff (RST_I)
      st_q != ST_RUN |=> ((flags_q >> sel_q) == '0);
  endproperty
  a_no_flag_beyond: assert property (p_no_flag_beyond) else $error("flag beyond wait"); // RULE2

  property p_wait_needs_osc;
    @(posedge MCLK_I) disable iff (RST_I)
      (st_q == ST_START && !OSC_STARTED_I) |=> st_q == ST_START && cnt_q == '0;
  endproperty
  a_wait_needs_osc: assert property (p_wait_needs_osc) else $error("count before start"); // RULE3

  property p_ring_halt;
    @(posedge MCLK_I) disable iff (RST_I)
      !HALT_OPTION_I |=> RING_OSC_EN_O;
  endproperty
  a_ring_halt: assert property (p_ring_halt) else $error("ring halted without option"); // RULE5

  property p_flags_sticky;
    @(posedge MCLK_I) disable iff (RST_I)
      st_q != ST_RUN |=> (flags_q & $past(flags_q)) == $past(flags_q);
  endproperty
  a_flags_sticky: assert property (p_flags_sticky) else $error("flag dropped"); // RULE7

  property p_flags_in_order;
    @(posedge MCLK_I) disable iff (RST_I)
      ((flags_q & (flags_q + 1'b1)) == '0);
  endproperty
  a_flags_in_order: assert property (p_flags_in_order) else $error("flag out of order"); // RULE7

  property p_entry_clears;
    @(posedge MCLK_I) disable iff (RST_I)
      s_stop_entry |=> (flags_q == '0 && !CPU_RUN_O);
  endproperty
  a_entry_clears: assert property (p_entry_clears) else $error("flags not cleared"); // RULE10

  property p_ring_div;
    @(posedge MCLK_I) disable iff (RST_I)
      ring_tick |=> !ring_tick [*2];
  endproperty
  a_ring_div: assert property (p_ring_div) else $error("ring tick too fast"); // RULE4 RULE6

  property p_resume;
    @(posedge MCLK_I) disable iff (RST_I)
      s_wait_done |=> CPU_RUN_O;
  endproperty
  a_resume: assert property (p_resume) else $error("cpu not resumed"); // RULE10

  property p_ring_period;
    @(posedge MCLK_I) disable iff (RST_I)
      ring_en_d |-> gap_q < GAP_MAX;
  endproperty
  a_ring_period: assert property (p_ring_period) else $error("ring period too long"); // RULE6

  property p_prescale_ring;
    @(posedge MCLK_I) disable iff (RST_I)
      (ctrl_q.src_ring && ring_tick) |=> PRESCALER_O == PRE_W'($past(pre_q) + 1'b1);
  endproperty
  a_prescale_ring: assert property (p_prescale_ring) else $error("ring tick missed"); // RULE4

  property p_prescale_hold;
    @(posedge MCLK_I) disable iff (RST_I)
      (ctrl_q.src_ring && !ring_tick) |=> PRESCALER_O == $past(pre_q);
  endproperty
  a_prescale_hold: assert property (p_prescale_hold) else $error("prescaler off ring"); // RULE4

  property p_stop_osc;
    @(posedge MCLK_I) disable iff (RST_I)
      st_q == ST_STOP |-> MAIN_OSC_EN_O == ctrl_q.src_ring;
  endproperty
  a_stop_osc: assert property (p_stop_osc) else $error("crystal enable wrong in stop"); // RULE10

  property p_sel_clamped;
    @(posedge MCLK_I) disable iff (RST_I)
      sel_q <= WAIT_SEL_MAX;
  endproperty
  a_sel_clamped: assert property (p_sel_clamped) else $error("wait select too long"); // RULE2

  property p_release_starts;
    @(posedge MCLK_I) disable iff (RST_I)
      (st_q == ST_STOP && RELEASE_I) |=> st_q == ST_START;
  endproperty
  a_release_starts: assert property (p_release_starts) else $error("release ignored"); // RULE3

  property p_cpu_held;
    @(posedge MCLK_I) disable iff (RST_I)
      (st_q != ST_RUN && st_d != ST_RUN) |=> !CPU_RUN_O;
  endproperty
  a_cpu_held: assert property (p_cpu_held) else $error("cpu ran during wait"); // RULE10
endmodule
`default_nettype wire
